// File: src/ddr_timing_pkg.sv
// Overview of operation
// - 1KB pages: four activates per 35/37.5 ns
// - 2KB pages: four activates span 45/50 ns
// - Column commands at least two clocks apart
// - Auto-precharge write: recovery plus precharge before activate
// - Write data to read at least 7.5 ns
// - Read to same-bank precharge at least 7.5 ns
// - Self-refresh exit: refresh cycle plus 10 ns
// - Self-refresh exit: 200 clocks before read; a mode set after exit reloads the read timer with 2 clocks
// - Precharge power-down exit: two clocks
// - Active power-down fast exit: two clocks to read
// - Slow exit: 8 or 7 minus AL to read
// - Clock enable held each level three clocks
// - Power-down termination switches on without clock timing
// - Termination change three clocks before power-down
// - Eight clocks after power-down before synchronous termination
// - Mode register set spaced two clocks
// - New termination setting applied within 12 ns
// - Calibration drive mode applied within 12 ns
// - 1KB pages: activates 7.5 ns apart
// - 2KB pages: activates 10 ns apart
// - Write strobe within quarter clock of edge; no write strobe is modelled here
// - Clock runs on after clock enable drops
package ddr_timing_pkg;

  // Clock periods, picoseconds
  localparam int SYS_PS = 20000;
  localparam int CK_PS  = 2 * SYS_PS;

  // Part options
  localparam bit PAGE_2KB   = 1'b0;
  localparam bit GRADE_FAST = 1'b1;
  localparam int ADD_LAT    = 0;
  localparam int NBANK      = 8;
  localparam int BANK_W     = 3;

  // Timing figures as printed
  localparam int FAW_PS  = PAGE_2KB ? (GRADE_FAST ? 45000 : 50000)
                                    : (GRADE_FAST ? 35000 : 37500);
  localparam int RRD_PS  = PAGE_2KB ? 10000 : 7500;
  localparam int WR_PS   = 15000;
  localparam int RP_PS   = 15000;
  localparam int WTR_PS  = 7500;
  localparam int RTP_PS  = 7500;
  localparam int RFC_PS  = 105000;
  localparam int XSNR_PS = RFC_PS + 10000;
  localparam int CCD_CK  = 2;
  localparam int XSRD_CK = 200;
  localparam int XP_CK   = 2;
  localparam int XARD_CK = 2;
  localparam int XARDS_CK = (GRADE_FAST ? 8 : 7) - ADD_LAT;
  localparam int CKE_CK  = 3;
  localparam int ANPD_CK = 3;
  localparam int AXPD_CK = 8;
  localparam int MRD_CK  = 2;
  localparam int WDATA_CK = 4;

  typedef logic [7:0] cnt_t;

  // Least time rounded up to whole link clocks
  function automatic cnt_t ck_of(input int ps);
    return cnt_t'((ps + CK_PS - 1) / CK_PS);
  endfunction

  // Cycle counts
  localparam cnt_t FAW_CYC  = ck_of(FAW_PS);
  localparam cnt_t RRD_CYC  = ck_of(RRD_PS);
  localparam cnt_t DAL_CYC  = cnt_t'(ck_of(WR_PS) + ck_of(RP_PS));
  localparam cnt_t WTR_CYC  = cnt_t'(WDATA_CK + ck_of(WTR_PS));
  localparam cnt_t RTP_CYC  = ck_of(RTP_PS);
  localparam cnt_t XSNR_CYC = ck_of(XSNR_PS);
  localparam cnt_t CCD_CYC  = cnt_t'(CCD_CK);
  localparam cnt_t XSRD_CYC = cnt_t'(XSRD_CK);
  localparam cnt_t XP_CYC   = cnt_t'(XP_CK);
  localparam cnt_t XARD_CYC = cnt_t'(XARD_CK);
  localparam cnt_t XARDS_CYC = cnt_t'(XARDS_CK);
  localparam cnt_t CKE_CYC  = cnt_t'(CKE_CK);
  localparam cnt_t ANPD_CYC = cnt_t'(ANPD_CK);
  localparam cnt_t AXPD_CYC = cnt_t'(AXPD_CK);
  localparam cnt_t MRD_CYC  = cnt_t'(MRD_CK);

  // Mode register argument fields
  localparam int ARG_W        = 4;
  localparam int ARG_TERM_LO  = 0;
  localparam int ARG_TERM_HI  = 1;
  localparam int ARG_DRV_BIT  = 2;
  localparam int ARG_SLOW_BIT = 3;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_WRA, CMD_PRE, CMD_MRS, CMD_REF
  } cmd_t;

  typedef enum logic [1:0] {ST_RUN, ST_PD, ST_SR} pstate_t;

endpackage

// File: src/ddr_link_if.sv
`timescale 1ns/1ps
interface ddr_link_if;
  import ddr_timing_pkg::*;
  logic                ck;   // Link clock from controller
  logic                cke;  // Clock enable
  cmd_t                cmd;  // Command
  logic [BANK_W-1:0]   bank; // Bank address
  logic [ARG_W-1:0]    arg;  // Mode argument
  logic                odt;  // Termination control

  modport ctrl (output ck, cke, cmd, bank, arg, odt);
  modport mem  (input  ck, cke, cmd, bank, arg, odt);
endinterface

// File: src/ddr_mem_end.sv
`timescale 1ns/1ps
module ddr_mem_end
  import ddr_timing_pkg::*;
(
  ddr_link_if.mem              link,      // Link from controller
  input  wire logic            rst,       // Async reset, active high
  output logic [NBANK-1:0]     open_q,    // Open bank map
  output logic                 term_q,    // Termination, posedge part
  output logic                 term_tail_q, // Termination, half-cycle tail
  output logic [1:0]           term_sel_q,  // Termination setting
  output logic                 drv_cal_q,   // Calibration drive mode
  output logic                 pd_q         // Power-down or self refresh
);
  logic       rst_m_q;
  logic       rst_l_q;
  logic [1:0] odt_p_q;
  cnt_t       dal_q [NBANK];
  logic [NBANK-1:0] pend_q;

  // Reset release synchronised to the link clock
  always_ff @(posedge link.ck or posedge rst)
    if (rst)
    begin
      rst_m_q <= 1'b1;
      rst_l_q <= 1'b1;
    end
    else
    begin
      rst_m_q <= 1'b0;
      rst_l_q <= rst_m_q;
    end

  // Power-down follows the sampled clock enable
  always_ff @(posedge link.ck or posedge rst_l_q)
    if (rst_l_q)
      pd_q <= 1'b0;
    else
      pd_q <= ~link.cke;

  // Termination pipeline; runs even in power-down
  // Two stages behind the sampling edge give the two-clock turn-on;
  // in power-down both stages track the pin so exit shows no stale level
  always_ff @(posedge link.ck or posedge rst_l_q)
    if (rst_l_q)
    begin
      odt_p_q <= 2'h0;
      term_q  <= 1'b0;
    end
    else if (pd_q)
    begin
      odt_p_q <= {2{link.odt}};
      term_q  <= link.odt;
    end
    else
    begin
      odt_p_q <= {odt_p_q[0], link.odt};
      term_q  <= odt_p_q[1];
    end

  // Half-cycle hold so turn-off lands at 2.5 clocks
  always_ff @(negedge link.ck or posedge rst_l_q)
    if (rst_l_q)
      term_tail_q <= 1'b0;
    else
      term_tail_q <= term_q & ~pd_q;

  // Mode settings take effect at the command edge
  always_ff @(posedge link.ck or posedge rst_l_q)
    if (rst_l_q)
    begin
      term_sel_q <= 2'h0;
      drv_cal_q  <= 1'b0;
    end
    else if (link.cke && link.cmd == CMD_MRS)
    begin
      term_sel_q <= link.arg[ARG_TERM_HI:ARG_TERM_LO];
      drv_cal_q  <= link.arg[ARG_DRV_BIT];
    end

  // Bank state with internal precharge after write recovery
  always_ff @(posedge link.ck or posedge rst_l_q)
    if (rst_l_q)
    begin
      open_q <= '0;
      pend_q <= '0;
      for (int i = 0; i < NBANK; i++)
        dal_q[i] <= 8'h00;
    end
    else if (link.cke)
    begin
      for (int i = 0; i < NBANK; i++)
        if (pend_q[i])
        begin
          if (dal_q[i] <= 8'h01)
          begin
            pend_q[i] <= 1'b0;
            open_q[i] <= 1'b0;
          end
          dal_q[i] <= dal_q[i] - 8'h01;
        end
      case (link.cmd)
        CMD_ACT: open_q[link.bank] <= 1'b1;
        CMD_PRE: open_q[link.bank] <= 1'b0;
        CMD_WRA:
        begin
          pend_q[link.bank] <= 1'b1;
          dal_q[link.bank]  <= DAL_CYC;
        end
        default: ;
      endcase
    end
endmodule

// File: src/ddr_ctrl_end.sv
`timescale 1ns/1ps
module ddr_ctrl_end
  import ddr_timing_pkg::*;
(
  input  wire logic                 clk_sys,   // System clock
  input  wire logic                 rst,       // Async reset, active high
  input  wire logic                 ce,        // Clock enable
  input  wire logic                 req_valid, // Command request
  input  wire ddr_timing_pkg::cmd_t req_cmd,   // Requested command
  input  wire logic [BANK_W-1:0]    req_bank,  // Requested bank
  input  wire logic [ARG_W-1:0]     req_arg,   // Mode argument
  input  wire logic                 odt_req,   // Wanted termination level
  input  wire logic                 pd_req,    // Power-down wanted
  input  wire logic                 sr_req,    // Self refresh wanted
  output logic                      req_ready_q, // Request taken
  output logic                      pd_q,      // In power-down
  output logic                      sr_q,      // In self refresh
  ddr_link_if.ctrl                  link       // Link to memory
);
  logic              ck_q;
  logic              cke_q;
  cmd_t              cmd_q;
  logic [BANK_W-1:0] bank_q;
  logic [ARG_W-1:0]  arg_q;
  logic              odt_q;
  pstate_t           st_q;
  logic              slow_q;
  logic [NBANK-1:0]  open_q;
  logic [15:0]       cyc_q;
  logic [15:0]       act_t_q [4];
  logic [2:0]        act_n_q;
  cnt_t rrd_q, ccd_q, nrd_q, rd_q, cke_c_q, odt_c_q, pdx_q;
  cnt_t dal_q [NBANK];
  cnt_t rtp_q [NBANK];
  logic              tick;
  logic              faw_ok;
  logic              ok;
  logic              issue;
  logic              pd_go;
  logic              pd_out;
  logic              odt_go;
  logic              cke_up;

  // Link outputs straight from flops
  assign link.ck   = ck_q;
  assign link.cke  = cke_q;
  assign link.cmd  = cmd_q;
  assign link.bank = bank_q;
  assign link.arg  = arg_q;
  assign link.odt  = odt_q;

  // Outputs change at the falling link edge
  assign tick = ce & ck_q;

  // Link clock divider; clock stops only in reset or while ce is low
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      ck_q <= 1'b0;
    else if (ce)
      ck_q <= ~ck_q;

  // Four-activate window check
  assign faw_ok = (act_n_q < 3'h4) ||
                  ((cyc_q - act_t_q[3]) >= 16'(FAW_CYC));

  // Spacing checks for the requested command
  always_comb
  begin
    ok = 1'b0;
    case (req_cmd)
      CMD_NOP: ok = 1'b1;
      CMD_ACT: ok = nrd_q == 8'h00 && rrd_q == 8'h00 && faw_ok &&
                    dal_q[req_bank] == 8'h00 && !open_q[req_bank];
      CMD_RD:  ok = rd_q == 8'h00 && ccd_q == 8'h00 && open_q[req_bank];
      CMD_WR,
      CMD_WRA: ok = nrd_q == 8'h00 && ccd_q == 8'h00 && open_q[req_bank];
      CMD_PRE: ok = nrd_q == 8'h00 && rtp_q[req_bank] == 8'h00;
      CMD_MRS: ok = nrd_q == 8'h00 && open_q == '0;
      CMD_REF: ok = nrd_q == 8'h00 && open_q == '0;
      default: ok = 1'b0;
    endcase
  end

  // Entry into and exit from low-power states
  // First clock enable rise after reset, once the low hold has run out
  assign cke_up = st_q == ST_RUN && !cke_q && cke_c_q == 8'h00;
  assign pd_go  = st_q == ST_RUN && cke_q && (pd_req || sr_req) &&
                  cke_c_q == 8'h00 && odt_c_q == 8'h00 &&
                  nrd_q == 8'h00 && (!sr_req || open_q == '0);
  assign pd_out = st_q != ST_RUN && cke_c_q == 8'h00 &&
                  ((st_q == ST_PD && !pd_req) || (st_q == ST_SR && !sr_req));
  assign issue  = st_q == ST_RUN && cke_q && !pd_go && req_valid && ok &&
                  req_cmd != CMD_NOP;
  assign odt_go = odt_req != odt_q && pdx_q == 8'h00 && !pd_go;

  // Power state and clock enable
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      st_q  <= ST_RUN;
      cke_q <= 1'b0;
      pd_q  <= 1'b0;
      sr_q  <= 1'b0;
    end
    else if (tick)
    begin
      if (cke_up)
        cke_q <= 1'b1;
      else if (pd_go)
      begin
        cke_q <= 1'b0;
        st_q  <= sr_req ? ST_SR : ST_PD;
        pd_q  <= ~sr_req;
        sr_q  <= sr_req;
      end
      else if (pd_out)
      begin
        cke_q <= 1'b1;
        st_q  <= ST_RUN;
        pd_q  <= 1'b0;
        sr_q  <= 1'b0;
      end
    end

  // Command launch, termination and request handshake
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      cmd_q       <= CMD_NOP;
      bank_q      <= '0;
      arg_q       <= '0;
      odt_q       <= 1'b0;
      slow_q      <= 1'b0;
      req_ready_q <= 1'b0;
    end
    else if (ce)
    begin
      req_ready_q <= tick & issue;
      if (tick)
      begin
        cmd_q <= CMD_NOP;
        if (pd_go && sr_req)
          cmd_q <= CMD_REF;
        else if (issue)
        begin
          cmd_q  <= req_cmd;
          bank_q <= req_bank;
          arg_q  <= req_arg;
          if (req_cmd == CMD_MRS)
            slow_q <= req_arg[ARG_SLOW_BIT];
        end
        if (odt_go)
          odt_q <= odt_req;
      end
    end

  // Timers count link clocks down to zero
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      rrd_q   <= 8'h00;
      ccd_q   <= 8'h00;
      nrd_q   <= 8'h00;
      rd_q    <= 8'h00;
      cke_c_q <= CKE_CYC;
      odt_c_q <= 8'h00;
      pdx_q   <= 8'h00;
      for (int i = 0; i < NBANK; i++)
      begin
        dal_q[i] <= 8'h00;
        rtp_q[i] <= 8'h00;
      end
    end
    else if (tick)
    begin
      rrd_q   <= (rrd_q != 8'h00) ? rrd_q - 8'h01 : 8'h00;
      ccd_q   <= (ccd_q != 8'h00) ? ccd_q - 8'h01 : 8'h00;
      nrd_q   <= (nrd_q != 8'h00) ? nrd_q - 8'h01 : 8'h00;
      rd_q    <= (rd_q != 8'h00) ? rd_q - 8'h01 : 8'h00;
      cke_c_q <= (cke_c_q != 8'h00) ? cke_c_q - 8'h01 : 8'h00;
      odt_c_q <= (odt_c_q != 8'h00) ? odt_c_q - 8'h01 : 8'h00;
      pdx_q   <= (pdx_q != 8'h00) ? pdx_q - 8'h01 : 8'h00;
      for (int i = 0; i < NBANK; i++)
      begin
        dal_q[i] <= (dal_q[i] != 8'h00) ? dal_q[i] - 8'h01 : 8'h00;
        rtp_q[i] <= (rtp_q[i] != 8'h00) ? rtp_q[i] - 8'h01 : 8'h00;
      end
      if (odt_go)
        odt_c_q <= ANPD_CYC;
      if (cke_up)
        cke_c_q <= CKE_CYC - 8'h01;
      else if (pd_go)
        cke_c_q <= CKE_CYC - 8'h01;
      else if (pd_out)
      begin
        cke_c_q <= CKE_CYC - 8'h01;
        pdx_q   <= AXPD_CYC;
        if (st_q == ST_SR)
        begin
          nrd_q <= XSNR_CYC;
          rd_q  <= XSRD_CYC;
        end
        else
        begin
          nrd_q <= XP_CYC;
          if (open_q == '0)
            rd_q <= XP_CYC;
          else
            rd_q <= slow_q ? XARDS_CYC : XARD_CYC;
        end
      end
      else if (issue)
        case (req_cmd)
          CMD_ACT: rrd_q <= RRD_CYC;
          CMD_RD:
          begin
            ccd_q <= CCD_CYC;
            rtp_q[req_bank] <= RTP_CYC;
          end
          CMD_WR,
          CMD_WRA:
          begin
            ccd_q <= CCD_CYC;
            rd_q  <= (rd_q > WTR_CYC) ? rd_q : WTR_CYC;
            if (req_cmd == CMD_WRA)
              dal_q[req_bank] <= DAL_CYC;
          end
          CMD_MRS:
          begin
            nrd_q <= MRD_CYC;
            rd_q  <= MRD_CYC;
          end
          default: ;
        endcase
    end

  // Bank map and activate history
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      open_q  <= '0;
      cyc_q   <= 16'h0000;
      act_n_q <= 3'h0;
      for (int i = 0; i < 4; i++)
        act_t_q[i] <= 16'h0000;
    end
    else if (tick)
    begin
      cyc_q <= cyc_q + 16'h0001;
      if (issue)
        case (req_cmd)
          CMD_ACT:
          begin
            open_q[req_bank] <= 1'b1;
            act_t_q[0] <= cyc_q;
            for (int i = 1; i < 4; i++)
              act_t_q[i] <= act_t_q[i-1];
            if (act_n_q < 3'h4)
              act_n_q <= act_n_q + 3'h1;
          end
          CMD_WRA,
          CMD_PRE: open_q[req_bank] <= 1'b0;
          default: ;
        endcase
    end
endmodule

// File: bench/ddr_link_asserts.sv
`timescale 1ns/1ps
module ddr_link_asserts
  import ddr_timing_pkg::*;
(
  input wire logic                 ck,  // Link clock
  input wire logic                 rst, // Async reset
  input wire logic                 cke, // Clock enable
  input wire ddr_timing_pkg::cmd_t cmd, // Command
  input wire logic                 odt  // Termination control
);
  logic was_hi_q; // Clock enable seen high
  logic in_sr_q;  // In self refresh
  cnt_t since_q;  // Cycles since refresh exit
  logic col;      // Column command
  logic sr_in;    // Self refresh entry

  // Command classes
  assign col   = cmd inside {CMD_RD, CMD_WR, CMD_WRA};
  assign sr_in = cmd == CMD_REF && !cke;

  // Power state flags
  always_ff @(posedge ck or posedge rst)
    if (rst)
    begin
      was_hi_q <= 1'h0;
      in_sr_q  <= 1'h0;
    end
    else
    begin
      was_hi_q <= was_hi_q | cke;
      in_sr_q  <= sr_in | (in_sr_q & !cke);
    end

  // Cycles after leaving self refresh
  always_ff @(posedge ck or posedge rst)
    if (rst)
      since_q <= 8'hFF;
    else if (sr_in || (in_sr_q && !cke))
      since_q <= 8'h00;
    else if (since_q != 8'hFF)
      since_q <= since_q + 8'h01;

  default clocking cb @(posedge ck); endclocking
  default disable iff (rst);

  // Return to active clocking
  sequence pd_exit;
    $rose(cke) && was_hi_q;
  endsequence
  sequence quiet2;
    cmd == CMD_NOP ##1 cmd == CMD_NOP;
  endsequence

  a_col_spacing: assert property (col |=> !col)
    else $error("column commands too close");
  a_wr_to_rd: assert property (cmd inside {CMD_WR, CMD_WRA}
    |=> (cmd != CMD_RD)[*4]) else $error("read too soon after write");
  a_pd_exit_quiet: assert property (pd_exit |-> quiet2)
    else $error("command too soon after power-down exit");
  a_odt_exit_hold: assert property (pd_exit |=> $stable(odt)[*7])
    else $error("termination changed after exit");
  a_odt_pd_entry: assert property ($fell(cke) |-> odt == $past(odt)
    && odt == $past(odt, 2) && odt == $past(odt, 3))
    else $error("termination changed before power-down");
  a_cke_high_hold: assert property ($rose(cke) |-> cke[*3])
    else $error("clock enable high too short");
  a_cke_low_hold: assert property ($fell(cke) |-> (!cke)[*3])
    else $error("clock enable low too short");
  a_mrs_spacing: assert property (cmd == CMD_MRS |=> cmd == CMD_NOP)
    else $error("command too soon after mode set");
  a_sr_read: assert property (cmd == CMD_RD |-> since_q >= XSRD_CYC)
    else $error("read too soon after self refresh");
  a_sr_other: assert property (!(cmd inside {CMD_NOP, CMD_RD})
    |-> since_q >= XSNR_CYC) else $error("command too soon after refresh");
endmodule

// File: bench/ddr2_command_timing_rules_test.sv
`timescale 1ns/1ps
module ddr2_command_timing_rules_test;
  import ddr_timing_pkg::*;
  logic              clk_sys   = 1'h0; // System clock
  logic              rst       = 1'h0; // Reset
  logic              ce        = 1'h1; // Clock enable
  logic              req_valid = 1'h0; // Request
  cmd_t              req_cmd   = CMD_NOP; // Command
  logic [BANK_W-1:0] req_bank  = '0;   // Bank
  logic [ARG_W-1:0]  req_arg   = '0;   // Argument
  logic              odt_req   = 1'h0; // Termination wanted
  logic              pd_req    = 1'h0; // Power-down wanted
  logic              sr_req    = 1'h0; // Self refresh wanted
  logic              req_ready_q, c_pd_q, c_sr_q, m_pd_q;
  logic              term_q, term_tail_q, drv_cal_q;
  logic [NBANK-1:0]  open_q;
  logic [1:0]        term_sel_q;
  logic [NBANK-1:0]  open_m = '0;      // Model of open banks
  int                n_errors = 0;
  int                n_compared = 0;

  ddr_link_if link ();
  ddr_ctrl_end u_ddr_ctrl_end (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_arg(req_arg), .odt_req(odt_req), .pd_req(pd_req),
    .sr_req(sr_req), .req_ready_q(req_ready_q), .pd_q(c_pd_q),
    .sr_q(c_sr_q), .link(link));
  ddr_mem_end u_ddr_mem_end (.link(link), .rst(rst), .open_q(open_q),
    .term_q(term_q), .term_tail_q(term_tail_q), .term_sel_q(term_sel_q),
    .drv_cal_q(drv_cal_q), .pd_q(m_pd_q));
  ddr_link_asserts u_ddr_link_asserts (.ck(link.ck), .rst(rst),
    .cke(link.cke), .cmd(link.cmd), .odt(link.odt));

  // System clock
  always #10 clk_sys = ~clk_sys;

  // Verdict
  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a level
  task automatic wait_lvl(ref logic s, input logic v);
    int i;
    for (i = 0; i < 2000 && s !== v; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    if (s !== v)
    begin
      n_errors++;
      $display("Error at %0t: wait timed out", $time);
      stop_test();
    end
  endtask

  // One request, then 12 ns past the sampling edge
  task automatic send(input cmd_t c, input logic [BANK_W-1:0] b,
                      input logic [ARG_W-1:0] a);
    @(negedge clk_sys);
    req_cmd = c;
    req_bank = b;
    req_arg = a;
    req_valid = 1'h1;
    wait_lvl(req_ready_q, 1'h1);
    @(negedge clk_sys);
    req_valid = 1'h0;
    @(posedge link.ck);
    #12;
  endtask

  // Half cycles from sampling edge to termination change
  task automatic odt_step(input logic v, input int lo, input int hi);
    int h;
    int first;
    first = 0;
    @(negedge clk_sys);
    odt_req = v;
    for (h = 0; h < 200 && link.odt !== v; h++)
    begin
      @(posedge clk_sys);
      #1;
    end
    if (link.odt !== v)
    begin
      n_errors++;
      $display("Error at %0t: termination request lost", $time);
      stop_test();
    end
    @(posedge link.ck);
    for (h = 1; h <= 8; h++)
    begin
      @(link.ck);
      #1;
      if (first == 0 && (term_q | term_tail_q) === v)
        first = h;
    end
    check(8'(first >= lo && first <= hi), 8'h01);
  endtask

  // Main sequence
  initial
  begin
    int i;
    logic [BANK_W-1:0] b;
    logic [BANK_W-1:0] k;
    logic [ARG_W-1:0] a;
    i = $urandom(32'h3024F95F);
    // Raise reset as an edge so every asynchronous reset sees it
    #1;
    rst = 1'h1;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'h0;
    check(open_q, 8'h00);
    check(8'({term_q, term_tail_q, m_pd_q}), 8'h00);
    // Let clock enable rise so the device leaves startup power-down
    repeat (8) @(posedge link.ck);
    #1;
    check(8'({link.cke, m_pd_q}), 8'h02);
    odt_step(1'h1, 4, 4);
    odt_step(1'h0, 5, 5);
    for (i = 0; i < 4; i++)
    begin
      a = ARG_W'($urandom);
      a[1:0] = i[1:0];
      a[ARG_DRV_BIT] = i[0];
      send(CMD_MRS, '0, a);
      check(8'({term_sel_q, drv_cal_q}), 8'({i[1:0], i[0]}));
    end
    k = BANK_W'($urandom);
    for (i = 0; i < NBANK; i++)
    begin
      b = BANK_W'(i) ^ k;
      send(CMD_ACT, b, '0);
      open_m[b] = 1'h1;
      check(open_q, open_m);
    end
    for (i = 0; i < 6; i++)
    begin
      send(i[0] ? CMD_RD : CMD_WR, BANK_W'($urandom), '0);
      check(open_q, open_m);
    end
    send(CMD_WRA, k, '0);
    repeat (DAL_CYC - 1) @(posedge link.ck);
    #1;
    check(open_q, open_m);
    @(posedge link.ck);
    #1;
    open_m[k] = 1'h0;
    check(open_q, open_m);
    send(CMD_ACT, k, '0);
    open_m[k] = 1'h1;
    @(negedge clk_sys);
    pd_req = 1'h1;
    wait_lvl(c_pd_q, 1'h1);
    repeat (2) @(posedge link.ck);
    #1;
    check(8'(m_pd_q), 8'h01);
    odt_step(1'h1, 1, 4);
    @(negedge clk_sys);
    pd_req = 1'h0;
    wait_lvl(c_pd_q, 1'h0);
    send(CMD_RD, k, '0);
    odt_step(1'h0, 5, 5);
    for (i = 0; i < NBANK; i++)
    begin
      send(CMD_PRE, BANK_W'(i), '0);
      open_m[i] = 1'h0;
      check(open_q, open_m);
    end
    @(negedge clk_sys);
    sr_req = 1'h1;
    wait_lvl(c_sr_q, 1'h1);
    @(negedge clk_sys);
    sr_req = 1'h0;
    wait_lvl(c_sr_q, 1'h0);
    send(CMD_ACT, k, '0);
    send(CMD_RD, k, '0);
    open_m[k] = 1'h1;
    check(open_q, open_m);
    @(negedge clk_sys);
    ce = 1'h0;
    repeat (6) @(negedge clk_sys);
    ce = 1'h1;
    check(open_q, open_m);
    stop_test();
  end
endmodule
